// File: include/tcc_pkg.sv
// Package with constants, types and the operation list for the capture/compare timer.
`default_nettype none
package tcc_pkg;
  localparam int          TCC_WIDTH       = 16;
  localparam int          TCC_FILT_LEN    = 3;
  localparam int          TCC_START_EDGES = 2;
  localparam logic [15:0] TCC_CNT_RST     = 16'h0000;
  localparam logic [15:0] TCC_CMP0_RST    = 16'hffff;
  localparam logic [15:0] TCC_CMP1_RST    = 16'hffff;
  localparam logic [1:0]  TCC_EDGE_RST    = 2'h0;

  typedef enum logic [1:0] {
    TCC_MODE_STOP  = 2'b00,
    TCC_MODE_FREE  = 2'b01,
    TCC_MODE_EVENT = 2'b10,
    TCC_MODE_RSVD  = 2'b11
  } tcc_mode_type;

  typedef enum logic [1:0] {
    TCC_ST_IDLE  = 2'b00,
    TCC_ST_ARM   = 2'b01,
    TCC_ST_COUNT = 2'b10
  } tcc_state_type;

  typedef struct packed {
    logic        wr0;
    logic        wr1;
    logic [15:0] data;
  } tcc_cmp_wr_type;

  typedef struct packed {
    logic match0_irq;
    logic match1_irq;
    logic toggle;
  } tcc_evt_type;
endpackage : tcc_pkg
`default_nettype wire

// File: hdl/tcc_filter.sv
// Two-flop synchroniser plus sampling noise limiter for one external input.
`default_nettype none
module tcc_filter
  import tcc_pkg::*;
#(
  parameter int LEN = TCC_FILT_LEN
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic pin,
  output var  logic level,
  output var  logic rise,
  output var  logic fall
);
  logic           meta_r;
  logic           sync_r;
  logic [LEN-1:0] hist_r;
  logic [LEN-1:0] hist_nxt;
  logic           level_r;
  logic           level_nxt;
  logic           rise_nxt;
  logic           fall_nxt;

  // The level changes only after LEN equal samples, so a pin edge lags internally.
  always_comb begin
    hist_nxt  = {hist_r[LEN-2:0], sync_r};
    level_nxt = level_r;
    if (&hist_r) begin
      level_nxt = 1'b1;
    end else if (~|hist_r) begin
      level_nxt = 1'b0;
    end
    rise_nxt = level_nxt & ~level_r;
    fall_nxt = ~level_nxt & level_r;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r  <= 1'b0;
      sync_r  <= 1'b0;
      hist_r  <= '0;
      level_r <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end else begin
      meta_r  <= pin;
      sync_r  <= meta_r;
      hist_r  <= hist_nxt;
      level_r <= level_nxt;
      rise    <= rise_nxt;
      fall    <= fall_nxt;
    end
  end

  assign level = level_r;
endmodule : tcc_filter
`default_nettype wire

// File: hdl/tcc_timer.sv
// Sixteen-bit timer/event counter with capture/compare channel zero, compare-only channel one and a toggle output.
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int WIDTH = TCC_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire tcc_mode_type     mode,
  input  wire logic             capture_source_select_bit,
  input  wire logic [1:0]       event_edge_sel,
  input  wire logic [1:0]       secondary_edge_sel,
  input  wire tcc_cmp_wr_type   cmp_wr,
  input  wire logic             primary_event_input,
  input  wire logic             secondary_capture_input,
  output var  logic [WIDTH-1:0] main_up_counter,
  output var  logic [WIDTH-1:0] capture_compare_reg_zero,
  output var  logic [WIDTH-1:0] capture_compare_reg_one,
  output var  logic             channel_zero_match_irq,
  output var  logic             channel_one_match_irq,
  output var  logic             timer_toggle_output,
  output var  logic             counting
);
  logic [1:0]    pin_vec;
  logic [1:0]    rise_vec;
  logic [1:0]    fall_vec;
  tcc_state_type state_r;
  tcc_state_type state_nxt;
  logic [1:0]    edges_r;
  logic [1:0]    edges_nxt;
  logic [WIDTH-1:0] cnt_nxt;
  logic [WIDTH-1:0] cmp0_nxt;
  logic [WIDTH-1:0] cmp1_nxt;
  tcc_evt_type   evt_nxt;
  logic          tog_nxt;
  logic          pri_edge;
  logic          sec_edge;
  logic          tick;

  // Edge select: bit0 enables rising, bit1 enables falling.
  function automatic logic edge_ok(input logic [1:0] sel, input logic r, input logic f);
    edge_ok = (sel[0] & r) | (sel[1] & f);
  endfunction : edge_ok

  assign pin_vec = {secondary_capture_input, primary_event_input};

  // Index 0 is the event input and index 1 the capture input; both see the same
  // sampling lag, so an edge acts on the counter several cycles after the pin moves.
  for (genvar gi = 0; gi < 2; gi++) begin : g_filt
    tcc_filter #(.LEN(TCC_FILT_LEN)) u_filt (
      .clock  (clock),
      .arst_n (arst_n),
      .pin    (pin_vec[gi]),
      .level  (),
      .rise   (rise_vec[gi]),
      .fall   (fall_vec[gi])
    );
  end : g_filt

  always_comb begin
    pri_edge  = edge_ok(event_edge_sel, rise_vec[0], fall_vec[0]);
    sec_edge  = edge_ok(secondary_edge_sel, rise_vec[1], fall_vec[1]);
    state_nxt = state_r;
    edges_nxt = edges_r;
    tick      = 1'b0;
    case (state_r)
      TCC_ST_IDLE: begin
        edges_nxt = TCC_EDGE_RST;
        if (mode == TCC_MODE_FREE) begin
          state_nxt = TCC_ST_COUNT;
        end else if (mode == TCC_MODE_EVENT) begin
          state_nxt = TCC_ST_ARM;
        end
      end
      TCC_ST_ARM: begin
        if (mode != TCC_MODE_EVENT) begin
          state_nxt = TCC_ST_IDLE;
        end else if (pri_edge) begin
          // The first increment follows the second valid edge.
          if (edges_r == 2'(TCC_START_EDGES - 1)) begin
            state_nxt = TCC_ST_COUNT;
            tick      = 1'b1;
          end else begin
            edges_nxt = edges_r + 2'h1;
          end
        end
      end
      TCC_ST_COUNT: begin
        if (mode == TCC_MODE_FREE) begin
          tick = 1'b1;
        end else if (mode == TCC_MODE_EVENT) begin
          tick = pri_edge;
        end else begin
          state_nxt = TCC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = TCC_ST_IDLE;
      end
    endcase
  end

  always_comb begin
    cnt_nxt  = main_up_counter;
    cmp0_nxt = capture_compare_reg_zero;
    cmp1_nxt = capture_compare_reg_one;
    tog_nxt  = timer_toggle_output;
    evt_nxt  = '0;
    if (state_nxt == TCC_ST_IDLE) begin
      cnt_nxt = TCC_CNT_RST;
    end else if (tick) begin
      cnt_nxt = main_up_counter + 1'b1;
    end
    // Compare is against the present count and register; a write in the same cycle
    // only takes part in the compare from the next cycle.
    if (state_r == TCC_ST_COUNT && main_up_counter == capture_compare_reg_zero) begin
      evt_nxt.match0_irq = 1'b1;
    end
    if (state_r == TCC_ST_COUNT && main_up_counter == capture_compare_reg_one) begin
      evt_nxt.match1_irq = 1'b1;
      tog_nxt            = ~tog_nxt;
    end
    if (sec_edge) begin
      evt_nxt.match0_irq = 1'b1;
      if (!capture_source_select_bit) begin
        cmp0_nxt = main_up_counter;
      end
    end
    // Software updates belong in the channel-zero service routine.
    if (cmp_wr.wr0) begin
      cmp0_nxt = cmp_wr.data;
    end
    if (cmp_wr.wr1) begin
      cmp1_nxt = cmp_wr.data;
      if (state_r == TCC_ST_COUNT) begin
        tog_nxt = ~timer_toggle_output;
      end
    end
  end

  // Control state: sequencer, start-edge count and the counting flag.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= TCC_ST_IDLE;
      edges_r  <= TCC_EDGE_RST;
      counting <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      edges_r  <= edges_nxt;
      counting <= (state_nxt == TCC_ST_COUNT);
    end
  end

  // Datapath state: counter, compare registers, interrupt pulses and toggle level.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      main_up_counter          <= TCC_CNT_RST;
      capture_compare_reg_zero <= TCC_CMP0_RST;
      capture_compare_reg_one  <= TCC_CMP1_RST;
      channel_zero_match_irq   <= 1'b0;
      channel_one_match_irq    <= 1'b0;
      timer_toggle_output      <= 1'b0;
    end else begin
      main_up_counter          <= cnt_nxt;
      capture_compare_reg_zero <= cmp0_nxt;
      capture_compare_reg_one  <= cmp1_nxt;
      channel_zero_match_irq   <= evt_nxt.match0_irq;
      channel_one_match_irq    <= evt_nxt.match1_irq;
      timer_toggle_output      <= tog_nxt;
    end
  end
endmodule : tcc_timer
`default_nettype wire

// File: test/tcc_monitor.sv
// Port checker for the capture/compare timer.
`default_nettype none
module tcc_monitor
  import tcc_pkg::*;
#(parameter int WIDTH = TCC_WIDTH) (
  input wire logic             clock,
  input wire logic             arst_n,
  input wire tcc_mode_type     mode,
  input wire logic             capture_source_select_bit,
  input wire tcc_cmp_wr_type   cmp_wr,
  input wire logic             secondary_capture_input,
  input wire logic [WIDTH-1:0] main_up_counter,
  input wire logic [WIDTH-1:0] capture_compare_reg_zero,
  input wire logic             channel_zero_match_irq,
  input wire logic             timer_toggle_output,
  input wire logic             counting
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_quiet; !channel_zero_match_irq [*3]; endsequence
  sequence s_late; ##[1:6] channel_zero_match_irq; endsequence
  property p_lag; $rose(secondary_capture_input) && capture_source_select_bit
    |=> s_quiet ##0 s_late; endproperty
  a_lag: assert property (p_lag) else $error("edge irq timing");
  property p_cap; capture_source_select_bit && !cmp_wr.wr0
    |=> $stable(capture_compare_reg_zero); endproperty
  a_cap: assert property (p_cap) else $error("capture not skipped");
  property p_tog; counting && cmp_wr.wr1 |=> $changed(timer_toggle_output); endproperty
  a_tog: assert property (p_tog) else $error("toggle missed");
  property p_idle; mode == TCC_MODE_EVENT && !counting |-> main_up_counter == '0; endproperty
  a_idle: assert property (p_idle) else $error("early count");
  property p_cnt; counting && mode == TCC_MODE_FREE
    |=> main_up_counter == $past(main_up_counter) + 1'b1; endproperty
  a_cnt: assert property (p_cnt) else $error("count step");
  property p_m0; counting && main_up_counter == capture_compare_reg_zero
    |=> channel_zero_match_irq; endproperty
  a_m0: assert property (p_m0) else $error("match irq missed");
endmodule : tcc_monitor
bind tcc_timer tcc_monitor #(.WIDTH(WIDTH)) u_mon (.*);
`default_nettype wire

// File: test/tcc_pins.sv
// Pin model that replays the bench's pin levels after a chosen lag in cycles.
`default_nettype none
module tcc_pins (
  input  wire logic       clock,
  input  wire logic [1:0] lvl,
  input  wire logic [3:0] lag,
  output var  logic [1:0] pin = 2'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0][1:0] hist_r = '0;
  always @(posedge clock) begin
    hist_r <= {hist_r[14:0], lvl};
    pin    <= hist_r[lag];
  end
endmodule : tcc_pins
`default_nettype wire

// File: test/tcc_timer_test.sv
// Scenario bench for the capture/compare timer.
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tcc_timer_test
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic           clock = 1'b0, arst_n = 1'b0, sel = 1'b0, irq0, irq1, tog, cnting, tg;
  logic [1:0]     lvl = 2'h0, pin, esel = 2'h1;
  logic [3:0]     lag = 4'h0;
  logic [15:0]    cnt, r0, r1;
  tcc_mode_type   mode = TCC_MODE_STOP;
  tcc_cmp_wr_type wr = '0;
  int             error_cnt = 0, n_tests = 0;
  tcc_pins u_pins (.clock(clock), .lvl(lvl), .lag(lag), .pin(pin));
  tcc_timer DUT (.clock(clock), .arst_n(arst_n), .mode(mode), .capture_source_select_bit(sel),
    .event_edge_sel(esel), .secondary_edge_sel(2'h1), .cmp_wr(wr),
    .primary_event_input(pin[0]), .secondary_capture_input(pin[1]), .main_up_counter(cnt),
    .capture_compare_reg_zero(r0), .capture_compare_reg_one(r1), .channel_zero_match_irq(irq0),
    .channel_one_match_irq(irq1), .timer_toggle_output(tog), .counting(cnting));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wrc(input logic w0, input logic w1, input logic [15:0] d);
    @(posedge clock) wr <= '{w0, w1, d};
    @(posedge clock) wr <= '0;
    #1;
  endtask : wrc
  task automatic upto(input logic [15:0] v);
    for (int i = 0; i < 300 && cnt !== v; i++) cyc(1);
  endtask : upto
  task automatic t_free;
    wrc(1'b1, 1'b1, 16'h0020);
    @(posedge clock) mode <= TCC_MODE_FREE;
    upto(16'h0020);
    `CHK("irq0", 1'b0, irq0)
    cyc(1);
    `CHK("irq0", 1'b1, irq0)
    `CHK("irq1", 1'b1, irq1)
  endtask : t_free
  task automatic t_rew;
    tg = tog;
    wrc(1'b0, 1'b1, 16'h0100);
    `CHK("toggle", ~tg, tog)
    `CHK("reg1", 16'h0100, r1)
    @(posedge clock) wr <= '{1'b0, 1'b1, 16'h0200};
    wrc(1'b0, 1'b1, 16'h0200);
    `CHK("toggle", ~tg, tog)
  endtask : t_rew
  task automatic t_cap;
    int n;
    @(posedge clock) begin sel <= 1'b1; lag <= 4'h9; end
    wrc(1'b1, 1'b0, 16'h8000);
    @(posedge clock) lvl <= 2'h2;
    for (n = 0; n < 40 && irq0 !== 1'b1; n++) cyc(1);
    `CHK("lag", 1'b1, n > 12)
    `CHK("irq0", 1'b1, irq0)
    `CHK("reg0", 16'h8000, r0)
    @(posedge clock) begin lvl <= 2'h0; lag <= 4'h0; end
    cyc(20);
  endtask : t_cap
  task automatic t_evt;
    @(posedge clock) mode <= TCC_MODE_STOP;
    @(posedge clock) begin esel <= 2'h3; mode <= TCC_MODE_EVENT; end
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) lvl[0] <= ~lvl[0];
      cyc(12);
      `CHK("count", 16'(i), cnt)
      `CHK("counting", i > 0, cnting)
    end
  endtask : t_evt
  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  initial forever #12.5 clock = ~clock;
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_free();
    t_rew();
    t_cap();
    t_evt();
    conclude();
  end
  initial begin
    #50us;
    error_cnt++;
    conclude();
  end
endmodule : tcc_timer_test
`default_nettype wire
